// >>> acs_sequencer.sv
`timescale 1ns/1ps
module acs_sequencer
	import acs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic rc_tick_i,
	input wire logic comp_i,
	output logic [11:0] trial_o,
	output logic hold_connect_o,
	output logic converter_on_o,
	output logic [3:0] chan_sel_o,
	output logic [ACS_NUM_PINS-1:0] analog_pins_o,
	output logic [1:0] ref_high_sel_o,
	output logic [1:0] ref_low_sel_o
);
	typedef struct packed {
		acs_state_type st;
		logic [1:0] clk_sel;
		logic [3:0] chs;
		logic go;
		logic on;
		logic just;
		logic [2:0] ref_cfg;
		logic [3:0] pcfg;
		logic done;
		logic [4:0] div;
		logic rc_half;
		logic [3:0] conversion_clock_period;
		logic [11:0] sar;
		logic [11:0] res;
		logic ack;
		logic [31:0] dat;
	} acs_regs_type;

	acs_regs_type s_q;
	acs_regs_type s_d;
	logic tick;
	logic half;
	logic wr;
	logic [3:0] idx;

	// Divider end count for the selected oscillator ratio.
	function automatic logic [4:0] acs_top(input logic [1:0] sel);
		if (sel == ACS_CLK_DIV2) begin
			return ACS_TOP2;
		end else if (sel == ACS_CLK_DIV8) begin
			return ACS_TOP8;
		end
		return ACS_TOP32;
	endfunction : acs_top

	// Divider count that marks the middle of a period.
	function automatic logic [4:0] acs_mid(input logic [1:0] sel);
		if (sel == ACS_CLK_DIV2) begin
			return ACS_MID2;
		end else if (sel == ACS_CLK_DIV8) begin
			return ACS_MID8;
		end
		return ACS_MID32;
	endfunction : acs_mid

	// Places the 12-bit result into the byte pair.
	// justify placement
	function automatic logic [15:0] acs_pair(input logic just,
		input logic [11:0] r);
		if (just) begin
			return {4'h0, r};
		end
		return {r, 4'h0};
	endfunction : acs_pair

	// Pins left analog by the port configuration code.
	function automatic logic [ACS_NUM_PINS-1:0] acs_mask(
		input logic [3:0] code);
		logic [ACS_NUM_PINS-1:0] m;
		m = '1;
		if (code > ACS_PCFG_ALL) begin
			m = m >> (code - ACS_PCFG_ALL);
		end
		return m;
	endfunction : acs_mask

	assign tick = s_q.on && ((s_q.clk_sel == ACS_CLK_RC) ? rc_tick_i :
		(s_q.div == acs_top(s_q.clk_sel)));
	assign half = s_q.on && ((s_q.clk_sel == ACS_CLK_RC) ? s_q.rc_half :
		(s_q.div == acs_mid(s_q.clk_sel)));
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack && wb_sel_i[0];
	assign idx = (s_q.conversion_clock_period == 4'h0) ? 4'hB : 4'(ACS_LAST_BIT_TAD - s_q.conversion_clock_period);

	// Next-state logic for bus, divider and sequencer.
	always_comb begin
		s_d = s_q;
		s_d.rc_half = s_q.on && (s_q.clk_sel == ACS_CLK_RC) && rc_tick_i;
		if (!s_q.on || s_q.clk_sel == ACS_CLK_RC ||
			s_q.div == acs_top(s_q.clk_sel)) begin
			s_d.div = 5'h00;
		end else begin
			s_d.div = 5'(s_q.div + 5'h01);
		end
		case (s_q.st)
			ACS_IDLE: begin
				if (s_q.go && tick) begin
					s_d.st = ACS_CONV;
					s_d.conversion_clock_period = 4'h0;
					s_d.sar = ACS_FIRST_TRIAL;
				end
			end
			ACS_CONV: begin
				if (tick) begin
					s_d.conversion_clock_period = 4'(s_q.conversion_clock_period + 4'h1);
					if (s_q.conversion_clock_period != 4'h0) begin
						s_d.sar[idx] = comp_i;
						if (idx != 4'h0) begin
							s_d.sar[4'(idx - 4'h1)] = 1'b1;
						end
					end
					if (s_q.conversion_clock_period == ACS_LAST_BIT_TAD) begin
						s_d.st = ACS_FINISH;
						s_d.done = 1'b1;
						s_d.res = {s_q.sar[11:1], comp_i};
					end
				end
			end
			ACS_FINISH: begin
				if (half) begin
					s_d.go = 1'b0;
					s_d.st = ACS_HOLDOFF;
					s_d.conversion_clock_period = 4'h0;
				end
			end
			default: begin
				if (tick) begin
					s_d.conversion_clock_period = 4'(s_q.conversion_clock_period + 4'h1);
					if (s_q.conversion_clock_period == ACS_HOLDOFF_LAST) begin
						s_d.st = ACS_IDLE;
					end
				end
			end
		endcase
		// Bus access: one wait state, write acts on the acked edge.
		s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
		s_d.dat = 32'h0000_0000;
		if (wb_adr_i == ACS_CTRL0_ADR) begin
			s_d.dat[7:0] = {s_q.clk_sel, s_q.chs[2:0], s_q.go, s_q.chs[3],
				s_q.on};
		end else if (wb_adr_i == ACS_CTRL1_ADR) begin
			s_d.dat[7:0] = {s_q.just, s_q.ref_cfg, s_q.pcfg};
		end else if (wb_adr_i == ACS_RESH_ADR) begin
			s_d.dat[15:0] = acs_pair(s_q.just, s_q.res) >> 8;
		end else if (wb_adr_i == ACS_RESL_ADR) begin
			s_d.dat[7:0] = 8'(acs_pair(s_q.just, s_q.res));
		end else if (wb_adr_i == ACS_STAT_ADR) begin
			s_d.dat[ACS_DONE_BIT] = s_q.done;
			s_d.dat[ACS_BUSY_BIT] = s_q.go;
		end
		if (wr && wb_adr_i == ACS_CTRL0_ADR) begin
			s_d.clk_sel = wb_dat_i[ACS_CLK_LO+:2];
			s_d.chs = {wb_dat_i[ACS_CHS3_BIT], wb_dat_i[ACS_CHS_LO+:3]};
			s_d.on = wb_dat_i[ACS_ON_BIT];
			if (!wb_dat_i[ACS_ON_BIT]) begin
				s_d.go = 1'b0;
				s_d.st = ACS_IDLE;
				s_d.div = 5'h00;
			end else if (!s_q.on) begin
				s_d.go = 1'b0;
			end else if (!wb_dat_i[ACS_GO_BIT]) begin
				if (s_q.st == ACS_CONV) begin
					s_d.res = s_q.sar & ~(12'h001 << idx);
					s_d.st = ACS_IDLE;
				end
				if (s_q.st != ACS_FINISH) begin
					s_d.go = 1'b0;
				end
			end else if (s_q.st != ACS_FINISH) begin
				s_d.go = 1'b1;
			end
		end
		if (wr && wb_adr_i == ACS_CTRL1_ADR) begin
			s_d.just = wb_dat_i[ACS_JUST_BIT];
			s_d.ref_cfg = wb_dat_i[ACS_REF_LO+:3];
			s_d.pcfg = wb_dat_i[ACS_PCFG_LO+:4];
		end
		// A completion in the same cycle beats the software clear.
		if (wr && wb_adr_i == ACS_STAT_ADR && !wb_dat_i[ACS_DONE_BIT] &&
			!(s_q.st == ACS_CONV && tick && s_q.conversion_clock_period == ACS_LAST_BIT_TAD)) begin
			s_d.done = 1'b0;
		end
		if (rst_i) begin
			s_d = '0;
			s_d.st = ACS_IDLE;
			s_d.res = s_q.res;
		end
	end

	// State register.
	always_ff @(posedge clk_i) begin
		s_q <= s_d;
	end

	// Analog side outputs, all taken from registers.
	always_comb begin
		analog_pins_o = acs_mask(s_q.pcfg);
		if (s_q.ref_cfg == ACS_REF_BOTH_EXT ||
			s_q.ref_cfg == ACS_REF_EXTH_GND) begin
			analog_pins_o[ACS_REF_POS_PIN] = 1'b1;
		end
		if (s_q.ref_cfg == ACS_REF_BOTH_EXT ||
			s_q.ref_cfg == ACS_REF_SUP_EXTL) begin
			analog_pins_o[ACS_REF_NEG_PIN] = 1'b1;
		end
		case (s_q.ref_cfg)
			3'h0: {ref_high_sel_o, ref_low_sel_o} = {ACS_RH_SUPPLY,
				ACS_RL_GROUND};
			3'h1: {ref_high_sel_o, ref_low_sel_o} = {ACS_RH_EXT, ACS_RL_EXT};
			3'h2: {ref_high_sel_o, ref_low_sel_o} = {ACS_RH_INT_HIGH,
				ACS_RL_INT_LOW};
			3'h3: {ref_high_sel_o, ref_low_sel_o} = {ACS_RH_EXT,
				ACS_RL_GROUND};
			3'h4: {ref_high_sel_o, ref_low_sel_o} = {ACS_RH_INT_HIGH,
				ACS_RL_GROUND};
			3'h5: {ref_high_sel_o, ref_low_sel_o} = {ACS_RH_SUPPLY,
				ACS_RL_EXT};
			3'h6: {ref_high_sel_o, ref_low_sel_o} = {ACS_RH_SUPPLY,
				ACS_RL_INT_LOW};
			default: {ref_high_sel_o, ref_low_sel_o} = {ACS_RH_INT_LOW,
				ACS_RL_GROUND};
		endcase
	end

	// hold charge kept, only the switch opens.
	assign hold_connect_o = s_q.on && (s_q.st == ACS_IDLE);
	assign trial_o = s_q.sar;
	assign converter_on_o = s_q.on;
	assign chan_sel_o = s_q.chs;
	assign wb_dat_o = s_q.dat;
	assign wb_ack_o = s_q.ack;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_ref_override;
		s_q.ref_cfg == ACS_REF_BOTH_EXT |-> analog_pins_o[ACS_REF_POS_PIN]
			&& analog_pins_o[ACS_REF_NEG_PIN];
	endproperty
	a_ref_override: assert property (p_ref_override)
		else $error("External reference pin not analog.");
	property p_start;
		s_q.st == ACS_IDLE && s_q.go && tick && !wr |=> s_q.st == ACS_CONV
			&& s_q.conversion_clock_period == 4'h0 && trial_o == ACS_FIRST_TRIAL;
	endproperty
	a_start: assert property (p_start)
		else $error("Conversion did not start on the period edge.");
	property p_settle;
		s_q.st == ACS_CONV && s_q.conversion_clock_period == 4'h0 && tick && !wr |=>
			trial_o == ACS_FIRST_TRIAL && s_q.conversion_clock_period == 4'h1;
	endproperty
	a_settle: assert property (p_settle)
		else $error("Settling period changed the trial word.");
	property p_abort;
		wr && wb_adr_i == ACS_CTRL0_ADR && s_q.on && wb_dat_i[ACS_ON_BIT]
			&& !wb_dat_i[ACS_GO_BIT] && s_q.st == ACS_CONV |=>
			!s_q.go && s_q.st == ACS_IDLE && s_q.res == ($past(s_q.sar) &
			~(12'h001 << $past(idx)));
	endproperty
	a_abort: assert property (p_abort)
		else $error("Abort did not store the partial value.");
	property p_same_write;
		wr && wb_adr_i == ACS_CTRL0_ADR && !s_q.on &&
			wb_dat_i[ACS_ON_BIT] && wb_dat_i[ACS_GO_BIT] |=> s_q.on && !s_q.go;
	endproperty
	a_same_write: assert property (p_same_write)
		else $error("Go survived the enabling write.");
	property p_div8;
		s_q.on && s_q.clk_sel == ACS_CLK_DIV8 && tick ##1
			(s_q.on && s_q.clk_sel == ACS_CLK_DIV8) [*8] |-> tick &&
			!$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3) &&
			!$past(tick, 4) && !$past(tick, 5) && !$past(tick, 6) &&
			!$past(tick, 7);
	endproperty
	a_div8: assert property (p_div8)
		else $error("Divide-by-eight period wrong.");
	property p_done;
		s_q.st == ACS_CONV && tick && s_q.conversion_clock_period == ACS_LAST_BIT_TAD |=>
			s_q.done && s_q.go && s_q.st == ACS_FINISH &&
			s_q.res == {$past(s_q.sar[11:1]), $past(comp_i)};
	endproperty
	a_done: assert property (p_done)
		else $error("Done flag or result not set at completion.");
	property p_go_clear;
		s_q.st == ACS_FINISH && half |=> !s_q.go && s_q.st == ACS_HOLDOFF;
	endproperty
	a_go_clear: assert property (p_go_clear)
		else $error("Go not cleared mid period.");
	property p_holdoff;
		s_q.st == ACS_HOLDOFF |-> !hold_connect_o;
	endproperty
	a_holdoff: assert property (p_holdoff)
		else $error("Hold reconnected during holdoff.");
	property p_justify;
		s_q.just |-> acs_pair(s_q.just, s_q.res) == {4'h0, s_q.res};
	endproperty
	a_justify: assert property (p_justify)
		else $error("Right justified high nibble not zero.");
	property p_off_idle;
		!s_q.on |-> !tick && s_q.div == 5'h00;
	endproperty
	a_off_idle: assert property (p_off_idle)
		else $error("Divider ran while converter off.");
	property p_msb_first;
		s_q.st == ACS_CONV && tick && s_q.conversion_clock_period == 4'h1 && !wr |=>
			trial_o[11] == $past(comp_i) && trial_o[10];
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("Most significant bit not decided first.");
endmodule : acs_sequencer

// >>> acs_pkg.sv
// Functional notes
// - External reference pin forced to analog.
// - Writing go starts a 13-period conversion.
// - One settling period, then twelve bit periods.
// - Clearing go aborts, partial result stored.
// - Setting on and go together drops go.
// - Clock select picks 2, 8, 32 or RC.
// - Done flag rises at 14th period start.
// - Go clears at mid 14th period, or one clock after its start with RC.
// - Hold stays disconnected two periods after completion.
// - Hold capacitor never discharged after conversion.
// - High and low reference sources are routed.
// - Reference field selects the reference pair.
// - Completion loads result and sets flag; go stays set.
// - Reset clears controls, keeps result bytes.
// - Justify bit selects right or left alignment.
package acs_pkg;
	localparam logic [7:0] ACS_CTRL0_ADR = 8'h00;
	localparam logic [7:0] ACS_CTRL1_ADR = 8'h04;
	localparam logic [7:0] ACS_RESH_ADR = 8'h08;
	localparam logic [7:0] ACS_RESL_ADR = 8'h0C;
	localparam logic [7:0] ACS_STAT_ADR = 8'h10;
	// Control zero fields.
	localparam int ACS_ON_BIT = 0;
	localparam int ACS_CHS3_BIT = 1;
	localparam int ACS_GO_BIT = 2;
	localparam int ACS_CHS_LO = 3;
	localparam int ACS_CLK_LO = 6;
	// Control one fields.
	localparam int ACS_PCFG_LO = 0;
	localparam int ACS_REF_LO = 4;
	localparam int ACS_JUST_BIT = 7;
	// Status fields.
	localparam int ACS_DONE_BIT = 0;
	localparam int ACS_BUSY_BIT = 1;
	// Clock select codes and divider end counts.
	localparam logic [1:0] ACS_CLK_DIV2 = 2'h0;
	localparam logic [1:0] ACS_CLK_DIV8 = 2'h1;
	localparam logic [1:0] ACS_CLK_DIV32 = 2'h2;
	localparam logic [1:0] ACS_CLK_RC = 2'h3;
	localparam logic [4:0] ACS_TOP2 = 5'h01;
	localparam logic [4:0] ACS_TOP8 = 5'h07;
	localparam logic [4:0] ACS_TOP32 = 5'h1F;
	localparam logic [4:0] ACS_MID2 = 5'h00;
	localparam logic [4:0] ACS_MID8 = 5'h03;
	localparam logic [4:0] ACS_MID32 = 5'h0F;
	// Conversion timing in conversion-clock periods.
	localparam logic [3:0] ACS_LAST_BIT_TAD = 4'hC;
	localparam logic [3:0] ACS_HOLDOFF_LAST = 4'h1;
	localparam logic [11:0] ACS_FIRST_TRIAL = 12'h800;
	// Reference codes and routing.
	localparam logic [2:0] ACS_REF_BOTH_EXT = 3'h1;
	localparam logic [2:0] ACS_REF_EXTH_GND = 3'h3;
	localparam logic [2:0] ACS_REF_SUP_EXTL = 3'h5;
	localparam logic [1:0] ACS_RH_SUPPLY = 2'h0;
	localparam logic [1:0] ACS_RH_EXT = 2'h1;
	localparam logic [1:0] ACS_RH_INT_HIGH = 2'h2;
	localparam logic [1:0] ACS_RH_INT_LOW = 2'h3;
	localparam logic [1:0] ACS_RL_GROUND = 2'h0;
	localparam logic [1:0] ACS_RL_EXT = 2'h1;
	localparam logic [1:0] ACS_RL_INT_LOW = 2'h2;
	localparam int ACS_NUM_PINS = 10;
	localparam int ACS_REF_POS_PIN = 3;
	localparam int ACS_REF_NEG_PIN = 2;
	localparam logic [3:0] ACS_PCFG_ALL = 4'h5;
	typedef enum logic [1:0] {
		ACS_IDLE, ACS_CONV, ACS_FINISH, ACS_HOLDOFF
	} acs_state_type;
endpackage : acs_pkg

// >>> tb.sv
`timescale 1ns/1ps
module tb
	import acs_pkg::*;
;
	localparam logic [15:0] HI_TAB = 16'hC264;
	localparam logic [15:0] LO_TAB = 16'h2424;
	logic clk_i;
	logic rst_i;
	logic wb_cyc_i;
	logic wb_stb_i;
	logic wb_we_i;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic rc_tick_i;
	logic comp_i;
	logic [11:0] trial_o;
	logic [11:0] tgt;
	logic hold_connect_o;
	logic converter_on_o;
	logic [3:0] chan_sel_o;
	logic [ACS_NUM_PINS-1:0] analog_pins_o;
	logic [1:0] ref_high_sel_o;
	logic [1:0] ref_low_sel_o;
	int bad_count;
	int n_compared;
	int cycles;
	int rc_cnt;

	acs_sequencer acs_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rc_tick_i(rc_tick_i),
		.comp_i(comp_i), .trial_o(trial_o), .hold_connect_o(hold_connect_o),
		.converter_on_o(converter_on_o), .chan_sel_o(chan_sel_o),
		.analog_pins_o(analog_pins_o), .ref_high_sel_o(ref_high_sel_o),
		.ref_low_sel_o(ref_low_sel_o));

	// Clock of 10 ns period.
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Comparator against the target, RC ticks every 5 clocks, hang guard.
	always @(posedge clk_i) begin
		comp_i <= (tgt >= trial_o);
		rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
		rc_tick_i <= (rc_cnt == 4);
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		if (bad_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [11:0] got,
		input logic [11:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One classic cycle; the answer is taken at the edge where ack is high.
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		// Only the bench timeout ends a wait for the answer.
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, q);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a,
		input logic [7:0] e);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, q);
		chk(nm, {4'h0, q}, {4'h0, e});
	endtask : rdc

	task automatic t_reset_values;
		rdc("ctrl0", ACS_CTRL0_ADR, 8'h00);
		rdc("ctrl1", ACS_CTRL1_ADR, 8'h00);
		rdc("status", ACS_STAT_ADR, 8'h00);
		rdc("unmapped", 8'h14, 8'h00);
	endtask : t_reset_values

	// go dropped when set together with on.
	task automatic t_on_go;
		wr(ACS_CTRL0_ADR, 8'h2F);
		@(posedge clk_i);
		chk("on", {11'h000, converter_on_o}, 12'h001);
		chk("chan", {8'h00, chan_sel_o}, 12'h00D);
		rdc("ctrl0 go", ACS_CTRL0_ADR, 8'h2B);
		wr(ACS_CTRL0_ADR, 8'h00);
	endtask : t_on_go

	task automatic t_refs;
		logic [1:0] h;
		logic [1:0] l;
		for (int c = 0; c < 8; c++) begin
			h = HI_TAB[2*c +: 2];
			l = LO_TAB[2*c +: 2];
			wr(ACS_CTRL1_ADR, {1'b0, c[2:0], 4'hF});
			@(posedge clk_i);
			chk("ref high", {10'h000, ref_high_sel_o}, {10'h000, h});
			chk("ref low", {10'h000, ref_low_sel_o}, {10'h000, l});
			chk("pins", {2'h0, analog_pins_o},
				{8'h00, h == 2'h1, l == 2'h1, 2'h0});
		end
		wr(ACS_CTRL1_ADR, 8'h08);
		@(posedge clk_i);
		chk("pins cfg", {2'h0, analog_pins_o}, 12'h07F);
	endtask : t_refs

	task automatic t_conv(input logic [1:0] sel, input logic just,
		input logic [11:0] t, input int p);
		int n;
		tgt <= t;
		wr(ACS_CTRL1_ADR, {just, 7'h00});
		wr(ACS_CTRL0_ADR, {sel, 6'h01});
		repeat (100) @(posedge clk_i);
		wr(ACS_CTRL0_ADR, {sel, 6'h05});
		n = 0;
		while (hold_connect_o === 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		n = 0;
		while (hold_connect_o !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		chk("span", {11'h000, n >= 15*p-2 && n <= 16*p+2}, 12'h001);
		// poll the go mirror and the done flag.
		rdc("status", ACS_STAT_ADR, 8'h01);
		rdc("res high", ACS_RESH_ADR, just ? {4'h0, t[11:8]} : t[11:4]);
		rdc("res low", ACS_RESL_ADR, just ? t[7:0] : {t[3:0], 4'h0});
		wr(ACS_STAT_ADR, 8'h00);
		rdc("done clr", ACS_STAT_ADR, 8'h00);
	endtask : t_conv

	// abort keeps the decided bits, the rest zero.
	task automatic t_abort;
		logic [7:0] h;
		logic [7:0] l;
		tgt <= 12'hA5C;
		wr(ACS_CTRL1_ADR, 8'h00);
		wr(ACS_CTRL0_ADR, 8'h81);
		repeat (100) @(posedge clk_i);
		wr(ACS_CTRL0_ADR, 8'h85);
		repeat (224) @(posedge clk_i);
		wr(ACS_CTRL0_ADR, 8'h81);
		rdc("go abort", ACS_CTRL0_ADR, 8'h81);
		wb(1'b0, ACS_RESH_ADR, 8'h00, h);
		wb(1'b0, ACS_RESL_ADR, 8'h00, l);
		chk("abort top", {8'h00, h[7:4]}, 12'h00A);
		chk("abort low", {4'h0, l}, 12'h000);
	endtask : t_abort

	// reset mid-conversion clears controls, keeps the result.
	task automatic t_reset_mid;
		logic [7:0] h;
		wb(1'b0, ACS_RESH_ADR, 8'h00, h);
		wr(ACS_CTRL0_ADR, 8'h81);
		wr(ACS_CTRL0_ADR, 8'h85);
		repeat (150) @(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("on rst", {11'h000, converter_on_o}, 12'h000);
		rdc("ctrl0 rst", ACS_CTRL0_ADR, 8'h00);
		rdc("res keep", ACS_RESH_ADR, h);
	endtask : t_reset_mid

	// Main sequence.
	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h00000000;
		tgt = 12'h000;
		bad_count = 0;
		n_compared = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset_values();
		t_on_go();
		t_refs();
		// period length and sleep use are not modelled here.
		t_conv(2'h0, 1'b1, 12'hABC, 2);
		t_conv(2'h1, 1'b0, 12'h5A3, 8);
		t_conv(2'h2, 1'b1, 12'hFFF, 32);
		t_conv(2'h3, 1'b0, 12'h001, 5);
		t_abort();
		t_reset_mid();
		tally_and_finish();
	end
endmodule : tb
